// [include/charger_link_if.sv]
// Serial link and open-drain status line between host and charger
`timescale 1ns/1ps
interface charger_link_if;
	logic link_clk;
	logic link_sel;
	logic link_mosi;
	logic link_miso;
	logic stat_o;
	logic stat_oe;
	logic stat_line;

	// Pull-up resolves the open-drain status line
	assign stat_line = stat_oe ? stat_o : 1'b1;

	modport device (
		input  link_clk,
		input  link_sel,
		input  link_mosi,
		input  stat_line,
		output link_miso,
		output stat_o,
		output stat_oe
	);
	modport host (
		output link_clk,
		output link_sel,
		output link_mosi,
		input  link_miso,
		input  stat_line
	);
endinterface

// [include/charger_pkg.sv]
// Shared constants and types for the charger supervisor and its host end
// Overview of operation
// - Boost mode only on boost-capable variants
// - High impedance stops charging, boosting, draws nothing
// - No host traffic: safety timer, default settings
// - Input overvoltage stops converter, faults, pulses, recovers
// - Power-on sinks input; 30 ms above minimum
// - Bad adaptor: sink off, pulse, code 011
// - Input near battery: sleep, switch and converter off
// - Input sag tapers current, sets special flag
// - Battery overvoltage stops converter, faults, pulses, recovers
// - Below short threshold charge with reduced current
// - Power-up 262 ms battery check, absent means hi-Z
// - Without detection, regulate defaults at power-up
// - Host termination: discharge sink 262 ms, recheck
// - Battery stays high present, else defaults, retry
// - Any host write swaps safety timer for watchdog
// - Host kick restarts watchdog, bit self-clears
// - Watchdog expiry restores defaults, fifteen-minute mode
// - Safety expiry stops charge, faults, pulses
// - Timer fault clears at power-on; status locked until read
// - Host mode at power-on keeps programmed settings
// - Fifteen-minute mode above low threshold stays hi-Z
// - Each fault gives one 128 us low pulse
package charger_pkg;
	localparam int CLK_PERIOD_NS  = 40;
	localparam int MS_NS          = 1_000_000;
	localparam int MS_CYCLES      = MS_NS / CLK_PERIOD_NS;
	localparam int STAT_PULSE_NS  = 128_000;
	localparam int STAT_PULSE_CYC = STAT_PULSE_NS / CLK_PERIOD_NS;
	localparam int ADAPT_TEST_MS  = 30;
	localparam int DETECT_MS      = 262;
	localparam int WATCHDOG_MS    = 32_000;
	localparam int SAFETY_MS      = 15 * 60 * 1000;
	localparam int RETRY_MS       = 100;
	localparam int LINK_HALF_CYC  = 8;

	// Frame layout, sent most significant bit first
	localparam int FRAME_BITS = 16;
	localparam int RW_BIT     = 15;
	localparam int ADDR_MSB   = 14;
	localparam int ADDR_LSB   = 12;

	localparam logic [2:0] REG_STATUS  = 3'h0;
	localparam logic [2:0] REG_CTRL    = 3'h1;
	localparam logic [2:0] REG_SPECIAL = 3'h5;

	localparam int CTRL_HZ      = 0;
	localparam int CTRL_BOOST   = 1;
	localparam int CTRL_TERM    = 2;
	localparam int CTRL_EN_STAT = 3;
	localparam int CTRL_KICK    = 7;
	localparam logic [7:0] CTRL_RESET = 8'h04;
	localparam int SPECIAL_BIT  = 4;

	localparam logic [2:0] FAULT_NONE        = 3'h0;
	localparam logic [2:0] FAULT_VIN_OVP     = 3'h1;
	localparam logic [2:0] FAULT_SLEEP       = 3'h2;
	localparam logic [2:0] FAULT_BAD_ADAPTOR = 3'h3;
	localparam logic [2:0] FAULT_BAT_OVP     = 3'h4;
	localparam logic [2:0] FAULT_NO_BAT      = 3'h5;
	localparam logic [2:0] FAULT_TIMER       = 3'h6;

	// Synchroniser bit positions: sense comparators, then link pins
	localparam int SNS_VBUS  = 0;
	localparam int SNS_VMIN  = 1;
	localparam int SNS_VOVP  = 2;
	localparam int SNS_SLEEP = 3;
	localparam int SNS_SAG   = 4;
	localparam int SNS_BOVP  = 5;
	localparam int SNS_SHORT = 6;
	localparam int SNS_RCH   = 7;
	localparam int SNS_LOWV  = 8;
	localparam int SNS_TERM  = 9;
	localparam int LNK_CLK   = 10;
	localparam int LNK_SEL   = 11;
	localparam int LNK_MOSI  = 12;
	localparam int SYNC_W    = 13;

	typedef enum logic [3:0] {
		ST_TEST   = 4'h0,
		ST_CHARGE = 4'h1,
		ST_DETECT = 4'h3,
		ST_DONE   = 4'h2,
		ST_RETRY  = 4'h6,
		ST_SLEEP  = 4'h7,
		ST_OVP    = 4'h5,
		ST_HIZ    = 4'h4,
		ST_TFAULT = 4'hC,
		ST_PWRDET = 4'hD
	} charge_state_t;

	typedef enum logic [2:0] {
		H_IDLE = 3'h0,
		H_LOW  = 3'h1,
		H_HIGH = 3'h3,
		H_END  = 3'h2,
		H_GAP  = 3'h6
	} host_state_t;
endpackage

// [verif/charger_link_sva.sv]
// Link framing and status-pulse checks between the host and charger ends
`timescale 1ns/1ps
module charger_link_sva (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Link and status line
	input wire logic link_clk,
	input wire logic link_sel,
	input wire logic link_mosi,
	input wire logic link_miso,
	input wire logic stat_o,
	input wire logic stat_oe,
	input wire logic stat_line
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	logic [11:0] pulse_cnt;
	logic [4:0]  bit_cnt;

	// Overlapping faults may stretch a pulse, so only its minimum is fixed
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pulse_cnt <= 12'h000;
			bit_cnt   <= 5'h00;
		end else begin
			pulse_cnt <= stat_oe ? pulse_cnt + 12'h001 : 12'h000;
			if (!link_sel) begin
				bit_cnt <= 5'h00;
			end else if ($rose(link_clk)) begin
				bit_cnt <= bit_cnt + 5'h01;
			end
		end
	end

	a_pulse_min: assert property ($fell(stat_oe) |-> pulse_cnt >= 12'hC80)
		else $error("status pulse shorter than 3200 cycles");
	a_pulse_low: assert property (stat_oe |-> !stat_o && !stat_line)
		else $error("status line not low while driven");
	a_clk_idle: assert property (!link_sel |-> !link_clk)
		else $error("link clock not idle low outside frame");
	a_first_half: assert property ($rose(link_sel) |-> !link_clk [*8] ##1 link_clk)
		else $error("first clock phase not eight cycles");
	a_high_half: assert property ($rose(link_clk) |-> link_clk [*8] ##1 !link_clk)
		else $error("clock high phase not eight cycles");
	a_mosi_hold: assert property (link_clk && $past(link_clk) |-> $stable(link_mosi))
		else $error("host data moved while clock high");
	a_frame_len: assert property ($fell(link_sel) |-> bit_cnt == 5'h10)
		else $error("frame not sixteen bits");
	a_sel_gap: assert property ($fell(link_sel) |-> !link_sel [*3])
		else $error("select gap under three cycles");

	c_pulse: cover property ($fell(stat_oe));
	c_frame: cover property ($fell(link_sel));
	c_miso: cover property (link_sel && link_miso);
endmodule

// [verif/tb_charger_mode_timer_supervisor.sv]
// Bench joining host and charger ends; drives comparators and commands
`timescale 1ns/1ps
module tb_charger_mode_timer_supervisor;
	logic        core_clk, rst;
	logic        vbus_present, vin_above_min, vin_overvoltage, vin_below_sleep;
	logic        vin_at_sag, bat_overvoltage, bat_below_short, bat_above_low;
	logic        bat_above_recharge, term_current_seen;
	logic        conv_on, boost_on, hi_z, adapt_sink_on, discharge_sink_on;
	logic        block_switch_on, short_mode, sag_limit, default_params;
	logic        cmd_valid, cmd_write, cmd_ready, rd_valid;
	logic [2:0]  cmd_addr, fault_code;
	logic [7:0]  cmd_data;
	logic [15:0] rd_data;
	logic [15:0] exp_q[$];
	int          err_total, num_checks;

	always #20 core_clk = ~core_clk;

	charger_link_if link ();
	// Short millisecond prescale keeps timer expiries within the run
	charger_supervisor #(.MS_CYCLES(10), .SAFE_MS(200), .WDOG_MS(50), .RETRY_DLY_MS(5),
		.DET_MS(20))
	i_charger_supervisor (.core_clk(core_clk), .rst(rst), .link(link),
		.vbus_present(vbus_present), .vin_above_min(vin_above_min),
		.vin_overvoltage(vin_overvoltage), .vin_below_sleep(vin_below_sleep),
		.vin_at_sag(vin_at_sag), .bat_overvoltage(bat_overvoltage),
		.bat_below_short(bat_below_short), .bat_above_recharge(bat_above_recharge),
		.bat_above_low(bat_above_low), .term_current_seen(term_current_seen),
		.conv_on(conv_on), .boost_on(boost_on), .hi_z(hi_z),
		.adapt_sink_on(adapt_sink_on), .discharge_sink_on(discharge_sink_on),
		.block_switch_on(block_switch_on), .short_mode(short_mode),
		.sag_limit(sag_limit), .default_params(default_params), .fault_code(fault_code));
	charger_host i_charger_host (.core_clk(core_clk), .rst(rst), .link(link),
		.cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
		.cmd_data(cmd_data), .cmd_ready(cmd_ready), .rd_data(rd_data), .rd_valid(rd_valid));
	charger_link_sva i_charger_link_sva (.core_clk(core_clk), .rst(rst),
		.link_clk(link.link_clk), .link_sel(link.link_sel), .link_mosi(link.link_mosi),
		.link_miso(link.link_miso), .stat_o(link.stat_o), .stat_oe(link.stat_oe),
		.stat_line(link.stat_line));

	task automatic finish_test();
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [2:0] got, input logic [2:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic cmp_rd(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	// Request strobed for one cycle; a frame unfinished after 400 cycles ends the run
	task automatic xfer(input logic w, input logic [2:0] a, input logic [7:0] d);
		int n;
		@(posedge core_clk);
		cmd_valid <= 1'b1;
		cmd_write <= w;
		cmd_addr  <= a;
		cmd_data  <= d;
		@(posedge core_clk);
		cmd_valid <= 1'b0;
		n = 0;
		do begin
			@(posedge core_clk);
			#1;
			n++;
		end while (cmd_ready !== 1'b1 && n < 400);
		if (n >= 400) begin
			err_total++;
			finish_test();
		end
	endtask

	task automatic rd(input logic [2:0] code, input logic sp);
		exp_q.push_back({5'h00, code, 3'h0, sp, 4'h0});
		xfer(1'b0, charger_pkg::REG_STATUS, 8'h00);
		cyc(20);
	endtask

	// Falling edge keeps clear of the edge that launches the answer
	always @(negedge core_clk) begin
		if (rd_valid === 1'b1) begin
			if (exp_q.size() == 0) begin
				err_total++;
				$display("ERROR t=%0t got %h exp none", $time, rd_data);
			end else begin
				cmp_rd(rd_data, exp_q.pop_front());
			end
		end
	end

	initial begin
		core_clk = 1'b0;
		rst = 1'b1;
		{vbus_present, vin_above_min, vin_overvoltage, vin_below_sleep} = 4'h0;
		{vin_at_sag, bat_overvoltage, bat_below_short, bat_above_low} = 4'h0;
		{bat_above_recharge, term_current_seen} = 2'b00;
		{cmd_valid, cmd_write, cmd_addr, cmd_data} = 13'h0000;
		void'($urandom(57933));
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk) {vbus_present, vin_above_min} <= 2'b11;
		cyc(50);
		chk(adapt_sink_on, 1'b1);
		cyc(400);
		chk(conv_on, 1'b1);
		chk(adapt_sink_on, 1'b0);
		chk(default_params, 1'b1);
		chk(block_switch_on, 1'b1);
		chk(hi_z, 1'b0);
		@(posedge core_clk) bat_below_short <= 1'b1;
		cyc(20);
		chk(short_mode, 1'b1);
		@(posedge core_clk) {bat_below_short, vin_at_sag} <= 2'b01;
		cyc(20);
		chk(sag_limit, 1'b1);
		rd(charger_pkg::FAULT_NONE, 1'b1);
		@(posedge core_clk) vin_at_sag <= 1'b0;
		xfer(1'b1, charger_pkg::REG_CTRL, charger_pkg::CTRL_RESET);
		chk(default_params, 1'b0);
		xfer(1'b1, 3'h2, 8'($urandom));
		for (int i = 0; i < 3; i++) begin
			xfer(1'b1, charger_pkg::REG_CTRL, 8'h84);
		end
		chk(default_params, 1'b0);
		xfer(1'b1, charger_pkg::REG_CTRL, 8'h07);
		chk(hi_z, 1'b1);
		chk(conv_on, 1'b0);
		chk(boost_on, 1'b0);
		xfer(1'b1, charger_pkg::REG_CTRL, 8'h06);
		chk(boost_on, 1'b1);
		xfer(1'b1, charger_pkg::REG_CTRL, charger_pkg::CTRL_RESET);
		chk(conv_on, 1'b1);
		// Absent battery first, then a present one after a fresh host entry
		xfer(1'b1, charger_pkg::REG_CTRL, 8'h84);
		@(posedge core_clk) {bat_above_recharge, term_current_seen} <= 2'b11;
		cyc(20);
		chk(discharge_sink_on, 1'b1);
		chk(conv_on, 1'b0);
		@(posedge core_clk) bat_above_recharge <= 1'b0;
		cyc(200);
		chk(discharge_sink_on, 1'b0);
		chk(fault_code, charger_pkg::FAULT_NO_BAT);
		rd(charger_pkg::FAULT_NO_BAT, 1'b0);
		xfer(1'b1, charger_pkg::REG_CTRL, 8'h84);
		@(posedge core_clk) bat_above_recharge <= 1'b1;
		cyc(220);
		chk(discharge_sink_on, 1'b0);
		chk(conv_on, 1'b0);
		@(posedge core_clk) {bat_above_recharge, term_current_seen} <= 2'b00;
		cyc(20);
		chk(conv_on, 1'b1);
		for (int i = 0; i < 2; i++) begin
			xfer(1'b1, charger_pkg::REG_CTRL, 8'h84);
			@(posedge core_clk) {bat_overvoltage, vin_overvoltage} <= i ? 2'b10 : 2'b01;
			cyc(20);
			chk(conv_on, 1'b0);
			chk(fault_code, i ? charger_pkg::FAULT_BAT_OVP : charger_pkg::FAULT_VIN_OVP);
			rd(i ? charger_pkg::FAULT_BAT_OVP : charger_pkg::FAULT_VIN_OVP, 1'b0);
			@(posedge core_clk) {bat_overvoltage, vin_overvoltage} <= 2'b00;
			cyc(20);
			chk(conv_on, 1'b1);
		end
		cyc(600);
		chk(default_params, 1'b1);
		chk(conv_on, 1'b1);
		cyc(2000);
		chk(conv_on, 1'b0);
		chk(fault_code, charger_pkg::FAULT_TIMER);
		rd(charger_pkg::FAULT_TIMER, 1'b0);
		chk(fault_code, charger_pkg::FAULT_TIMER);
		@(posedge core_clk) vbus_present <= 1'b0;
		cyc(20);
		@(posedge core_clk) {vbus_present, bat_below_short} <= 2'b11;
		cyc(400);
		chk(fault_code, charger_pkg::FAULT_NONE);
		chk(conv_on, 1'b1);
		chk(default_params, 1'b1);
		// Leaving short mode after power-up starts the battery check
		@(posedge core_clk) bat_below_short <= 1'b0;
		cyc(20);
		chk(conv_on, 1'b0);
		cyc(200);
		chk(conv_on, 1'b1);
		@(posedge core_clk) vin_below_sleep <= 1'b1;
		cyc(20);
		chk(conv_on, 1'b0);
		chk(block_switch_on, 1'b0);
		rd(charger_pkg::FAULT_SLEEP, 1'b0);
		@(posedge core_clk) {vbus_present, vin_below_sleep, vin_above_min} <= 3'b000;
		cyc(20);
		@(posedge core_clk) vbus_present <= 1'b1;
		cyc(40);
		chk(adapt_sink_on, 1'b0);
		chk(fault_code, charger_pkg::FAULT_BAD_ADAPTOR);
		@(posedge core_clk) {vin_above_min, bat_above_low} <= 2'b11;
		cyc(500);
		chk(hi_z, 1'b1);
		chk(conv_on, 1'b0);
		chk(exp_q.size() == 0, 1'b1);
		finish_test();
	end
endmodule

// [verilog/charger_host.sv]
// Host end: turns user commands into link frames and returns read data
`timescale 1ns/1ps
module charger_host #(
	parameter int HALF_CYC = charger_pkg::LINK_HALF_CYC
) (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst,
	// Link to charger
	charger_link_if.host     link,
	// Command port
	input  wire logic        cmd_valid,
	input  wire logic        cmd_write,
	input  wire logic [2:0]  cmd_addr,
	input  wire logic [7:0]  cmd_data,
	output logic             cmd_ready,
	// Read answer
	output logic [15:0]      rd_data,
	output logic             rd_valid
);
	typedef struct packed {
		charger_pkg::host_state_t st;
		logic [7:0]               div;
		logic [3:0]               bitn;
		logic [15:0]              sh;
		logic [15:0]              rx;
		logic                     wr;
		logic                     clk;
		logic                     sel;
		logic                     mosi;
		logic                     s1;
		logic                     s2;
		logic                     s3;
		logic                     miso_f;
		logic [15:0]              rd_data;
		logic                     rd_valid;
	} host_t;

	host_t q;
	host_t n;
	logic  tick;
	logic  miso_now;

	always_comb begin
		n = q;
		n.rd_valid = 1'b0;
		n.s1 = link.link_miso;
		n.s2 = q.s1;
		n.s3 = q.s2;
		miso_now = (q.s2 == q.s3) ? q.s2 : q.miso_f;
		n.miso_f = miso_now;
		tick = q.div == 8'(HALF_CYC - 1);
		n.div = (tick || q.st == charger_pkg::H_IDLE) ? 8'h00 : q.div + 8'h01;
		case (q.st)
			charger_pkg::H_IDLE: begin
				if (cmd_valid) begin
					// Write frames move the charger into host mode
					n.sh = {cmd_write, cmd_addr, 4'h0, cmd_data};
					n.wr = cmd_write;
					n.sel = 1'b1;
					n.clk = 1'b0;
					n.mosi = cmd_write;
					n.bitn = 4'h0;
					n.st = charger_pkg::H_LOW;
				end
			end
			charger_pkg::H_LOW: begin
				if (tick) begin
					n.clk = 1'b1;
					n.st = charger_pkg::H_HIGH;
				end
			end
			charger_pkg::H_HIGH: begin
				if (tick) begin
					n.rx = {q.rx[14:0], miso_now};
					n.clk = 1'b0;
					if (q.bitn == 4'hF) begin
						n.st = charger_pkg::H_END;
					end else begin
						n.bitn = q.bitn + 4'h1;
						n.sh = {q.sh[14:0], 1'b0};
						n.mosi = q.sh[14];
						n.st = charger_pkg::H_LOW;
					end
				end
			end
			charger_pkg::H_END: begin
				if (tick) begin
					n.sel = 1'b0;
					n.mosi = 1'b0;
					n.st = charger_pkg::H_GAP;
				end
			end
			default: begin
				if (tick) begin
					// Read of status unlocks fault reporting
					n.rd_data = q.rx;
					n.rd_valid = !q.wr;
					n.st = charger_pkg::H_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			q <= '0;
			q.st <= charger_pkg::H_IDLE;
		end else begin
			q <= n;
		end
	end

	assign cmd_ready = q.st == charger_pkg::H_IDLE;
	assign link.link_clk = q.clk;
	assign link.link_sel = q.sel;
	assign link.link_mosi = q.mosi;
	assign rd_data = q.rd_data;
	assign rd_valid = q.rd_valid;
endmodule

// [verilog/charger_supervisor.sv]
// Charger supervisory logic: modes, faults, detection, timers, link slave
//
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module charger_supervisor #(
	parameter bit BOOST_CAPABLE  = 1'b1,
	parameter bit DETECT_CAPABLE = 1'b1,
	parameter int MS_CYCLES      = charger_pkg::MS_CYCLES,
	parameter int ADAPT_MS       = charger_pkg::ADAPT_TEST_MS,
	parameter int DET_MS         = charger_pkg::DETECT_MS,
	parameter int WDOG_MS        = charger_pkg::WATCHDOG_MS,
	parameter int SAFE_MS        = charger_pkg::SAFETY_MS,
	parameter int RETRY_DLY_MS   = charger_pkg::RETRY_MS
) (
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst,
	// Link to host
	charger_link_if.device  link,
	// Analog comparator levels
	input  wire logic       vbus_present,
	input  wire logic       vin_above_min,
	input  wire logic       vin_overvoltage,
	input  wire logic       vin_below_sleep,
	input  wire logic       vin_at_sag,
	input  wire logic       bat_overvoltage,
	input  wire logic       bat_below_short,
	input  wire logic       bat_above_recharge,
	input  wire logic       bat_above_low,
	input  wire logic       term_current_seen,
	// Power stage controls
	output logic            conv_on,
	output logic            boost_on,
	output logic            hi_z,
	output logic            adapt_sink_on,
	output logic            discharge_sink_on,
	output logic            block_switch_on,
	output logic            short_mode,
	output logic            sag_limit,
	output logic            default_params,
	output logic [2:0]      fault_code
);
	typedef struct packed {
		logic [charger_pkg::SYNC_W-1:0] s1;
		logic [charger_pkg::SYNC_W-1:0] s2;
		logic [charger_pkg::SYNC_W-1:0] s3;
		logic [charger_pkg::SYNC_W-1:0] flt;
		charger_pkg::charge_state_t     st;
		logic [15:0]                    pre;
		logic [19:0]                    seq_cnt;
		logic [19:0]                    tmr_cnt;
		logic                           host_mode;
		logic                           pwrup_check;
		logic [7:0]                     ctrl;
		logic [2:0]                     fault;
		logic                           status_lock;
		logic                           special;
		logic [11:0]                    pulse_cnt;
		logic [15:0]                    rx;
		logic [15:0]                    tx;
		logic [4:0]                     nbits;
		logic                           miso;
	} sup_t;

	sup_t q;
	sup_t n;

	logic [charger_pkg::SYNC_W-1:0] f;
	logic [charger_pkg::SYNC_W-1:0] rise;
	logic [charger_pkg::SYNC_W-1:0] fall;
	logic                           tick;
	logic                           seq_done_adapt;
	logic                           seq_done_det;
	logic                           seq_done_retry;
	logic                           fault_ev;
	logic [2:0]                     ev_code;
	logic                           tmr_run;
	logic                           tmr_exp;
	logic                           boost_sel;

	assign boost_sel = BOOST_CAPABLE && q.ctrl[charger_pkg::CTRL_BOOST]
		&& !q.ctrl[charger_pkg::CTRL_HZ];

	always_comb begin
		n = q;
		fault_ev = 1'b0;
		ev_code = charger_pkg::FAULT_NONE;

		// Three-stage sync; a level counts once stages two and three agree
		n.s1 = {link.link_mosi, link.link_sel, link.link_clk, term_current_seen,
			bat_above_low, bat_above_recharge, bat_below_short, bat_overvoltage,
			vin_at_sag, vin_below_sleep, vin_overvoltage, vin_above_min, vbus_present};
		n.s2 = q.s1;
		n.s3 = q.s2;
		f = (q.s2 & q.s3) | (q.flt & (q.s2 ^ q.s3));
		n.flt = f;
		rise = f & ~q.flt;
		fall = ~f & q.flt;

		// One millisecond prescaler shared by every interval but the status pulse
		tick = (q.pre == 16'(MS_CYCLES - 1));
		n.pre = tick ? 16'h0000 : q.pre + 16'h0001;
		if (tick) begin
			n.seq_cnt = q.seq_cnt + 20'h00001;
		end
		seq_done_adapt = tick && (q.seq_cnt == 20'(ADAPT_MS - 1));
		seq_done_det = tick && (q.seq_cnt == 20'(DET_MS - 1));
		seq_done_retry = tick && (q.seq_cnt == 20'(RETRY_DLY_MS - 1));

		// Link slave: shift in on clock rise, shift out on clock fall
		if (rise[charger_pkg::LNK_SEL]) begin
			n.nbits = 5'h00;
			n.tx = {5'h00, q.fault, 3'h0, q.special, 4'h0};
			n.miso = q.fault[2] & 1'b0;
		end else if (f[charger_pkg::LNK_SEL]) begin
			if (rise[charger_pkg::LNK_CLK] && q.nbits != 5'h10) begin
				n.rx = {q.rx[14:0], f[charger_pkg::LNK_MOSI]};
				n.nbits = q.nbits + 5'h01;
			end
			if (fall[charger_pkg::LNK_CLK]) begin
				n.tx = {q.tx[14:0], 1'b0};
				n.miso = q.tx[14];
			end
		end
		if (fall[charger_pkg::LNK_SEL] && q.nbits == 5'h10) begin
			if (q.rx[charger_pkg::RW_BIT]) begin
				if (!q.host_mode) begin
					n.host_mode = 1'b1;
					n.tmr_cnt = 20'h00000;
				end
				if (q.rx[charger_pkg::ADDR_MSB:charger_pkg::ADDR_LSB] == charger_pkg::REG_CTRL) begin
					n.ctrl = q.rx[7:0];
					n.ctrl[charger_pkg::CTRL_KICK] = 1'b0;
					if (q.rx[charger_pkg::CTRL_KICK]) begin
						n.tmr_cnt = 20'h00000;
					end
				end
			end else if (q.rx[charger_pkg::ADDR_MSB:charger_pkg::ADDR_LSB]
				== charger_pkg::REG_STATUS) begin
				n.status_lock = 1'b0;
			end
		end

		// Safety timer without host, watchdog with host
		tmr_run = q.host_mode || q.st == charger_pkg::ST_CHARGE
			|| q.st == charger_pkg::ST_PWRDET;
		tmr_exp = tmr_run && tick && (q.tmr_cnt == (q.host_mode ?
			20'(WDOG_MS - 1) : 20'(SAFE_MS - 1)));
		if (tmr_run && tick) begin
			n.tmr_cnt = q.tmr_cnt + 20'h00001;
		end

		case (q.st)
			charger_pkg::ST_TEST: begin
				if (!f[charger_pkg::SNS_VMIN]) begin
					fault_ev = 1'b1;
					ev_code = charger_pkg::FAULT_BAD_ADAPTOR;
					n.st = charger_pkg::ST_RETRY;
					n.seq_cnt = 20'h00000;
				end else if (seq_done_adapt) begin
					n.tmr_cnt = 20'h00000;
					n.pwrup_check = f[charger_pkg::SNS_SHORT];
					if (!q.host_mode && f[charger_pkg::SNS_LOWV]) begin
						n.st = charger_pkg::ST_HIZ;
					end else begin
						n.st = charger_pkg::ST_CHARGE;
					end
				end
			end
			charger_pkg::ST_RETRY: begin
				if (seq_done_retry) begin
					n.st = charger_pkg::ST_TEST;
					n.seq_cnt = 20'h00000;
				end
			end
			charger_pkg::ST_CHARGE: begin
				if (q.ctrl[charger_pkg::CTRL_HZ]) begin
					n.st = charger_pkg::ST_HIZ;
				end else if (DETECT_CAPABLE && q.pwrup_check && !q.host_mode
					&& fall[charger_pkg::SNS_SHORT]) begin
					n.st = charger_pkg::ST_PWRDET;
					n.seq_cnt = 20'h00000;
				end else if (q.host_mode && q.ctrl[charger_pkg::CTRL_TERM]
					&& f[charger_pkg::SNS_RCH] && f[charger_pkg::SNS_TERM]) begin
					n.st = charger_pkg::ST_DETECT;
					n.seq_cnt = 20'h00000;
				end
			end
			charger_pkg::ST_PWRDET: begin
				if (seq_done_det) begin
					n.pwrup_check = 1'b0;
					if (f[charger_pkg::SNS_RCH]) begin
						n.st = charger_pkg::ST_HIZ;
						fault_ev = 1'b1;
						ev_code = charger_pkg::FAULT_NO_BAT;
					end else begin
						n.st = charger_pkg::ST_CHARGE;
					end
				end
			end
			charger_pkg::ST_DETECT: begin
				if (seq_done_det) begin
					if (f[charger_pkg::SNS_RCH]) begin
						n.st = charger_pkg::ST_DONE;
					end else begin
						n.ctrl = charger_pkg::CTRL_RESET;
						n.st = charger_pkg::ST_RETRY;
						n.seq_cnt = 20'h00000;
						fault_ev = 1'b1;
						ev_code = charger_pkg::FAULT_NO_BAT;
					end
				end
			end
			charger_pkg::ST_DONE: begin
				if (!f[charger_pkg::SNS_RCH]) begin
					n.st = charger_pkg::ST_CHARGE;
				end
			end
			charger_pkg::ST_OVP: begin
				if (!f[charger_pkg::SNS_VOVP] && !f[charger_pkg::SNS_BOVP]) begin
					n.st = charger_pkg::ST_CHARGE;
				end
			end
			charger_pkg::ST_SLEEP: begin
				if (!f[charger_pkg::SNS_SLEEP]) begin
					n.st = charger_pkg::ST_CHARGE;
				end
			end
			charger_pkg::ST_HIZ: begin
				if (q.host_mode && !q.ctrl[charger_pkg::CTRL_HZ]) begin
					n.st = charger_pkg::ST_CHARGE;
				end
			end
			default: begin
				n.st = q.st; // Timer fault holds until power-on
			end
		endcase

		// Protection overrides any active charge state
		if (q.st == charger_pkg::ST_CHARGE || q.st == charger_pkg::ST_DETECT
			|| q.st == charger_pkg::ST_DONE || q.st == charger_pkg::ST_PWRDET) begin
			if (f[charger_pkg::SNS_VOVP] || f[charger_pkg::SNS_BOVP]) begin
				n.st = charger_pkg::ST_OVP;
				fault_ev = 1'b1;
				ev_code = f[charger_pkg::SNS_VOVP] ? charger_pkg::FAULT_VIN_OVP
					: charger_pkg::FAULT_BAT_OVP;
			end else if (f[charger_pkg::SNS_SLEEP] && f[charger_pkg::SNS_VMIN]) begin
				n.st = charger_pkg::ST_SLEEP;
				fault_ev = 1'b1;
				ev_code = charger_pkg::FAULT_SLEEP;
			end
		end

		if (tmr_exp) begin
			if (q.host_mode) begin
				n.host_mode = 1'b0;
				n.ctrl = charger_pkg::CTRL_RESET;
				n.tmr_cnt = 20'h00000;
			end else begin
				n.st = charger_pkg::ST_TFAULT;
				fault_ev = 1'b1;
				ev_code = charger_pkg::FAULT_TIMER;
			end
		end

		// Input power-on restarts adaptor test; clears any timer fault
		if (rise[charger_pkg::SNS_VBUS]) begin
			n.st = charger_pkg::ST_TEST;
			n.seq_cnt = 20'h00000;
			n.fault = charger_pkg::FAULT_NONE;
			n.status_lock = 1'b0;
			if (!q.host_mode) begin
				n.ctrl = charger_pkg::CTRL_RESET;
			end
		end else if (!f[charger_pkg::SNS_VBUS]) begin
			n.st = charger_pkg::ST_TEST;
			n.seq_cnt = 20'h00000;
			fault_ev = 1'b0;
		end

		// Set wins over a status read in the same cycle
		if (fault_ev) begin
			n.pulse_cnt = 12'(charger_pkg::STAT_PULSE_CYC);
			if (!q.status_lock) begin
				n.fault = ev_code;
			end
			n.status_lock = 1'b1;
		end else if (q.pulse_cnt != 12'h000) begin
			n.pulse_cnt = q.pulse_cnt - 12'h001;
		end

		n.special = conv_on && f[charger_pkg::SNS_SAG];
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			q <= '0;
			q.st <= charger_pkg::ST_TEST;
			q.ctrl <= charger_pkg::CTRL_RESET;
		end else begin
			q <= n;
		end
	end

	// Converter runs only in charge state; boost takes it over
	assign boost_on = boost_sel && q.st == charger_pkg::ST_CHARGE;
	assign conv_on = q.st == charger_pkg::ST_CHARGE && !boost_sel;
	assign hi_z = q.st == charger_pkg::ST_HIZ;
	assign adapt_sink_on = q.st == charger_pkg::ST_TEST && q.flt[charger_pkg::SNS_VBUS];
	assign discharge_sink_on = q.st == charger_pkg::ST_DETECT;
	assign block_switch_on = q.st != charger_pkg::ST_SLEEP && q.flt[charger_pkg::SNS_VBUS];
	assign short_mode = conv_on && q.flt[charger_pkg::SNS_SHORT];
	assign sag_limit = conv_on && q.flt[charger_pkg::SNS_SAG];
	assign default_params = !q.host_mode;
	assign fault_code = q.fault;
	assign link.link_miso = q.miso;
	assign link.stat_o = 1'b0;
	assign link.stat_oe = q.pulse_cnt != 12'h000
		|| (conv_on && q.ctrl[charger_pkg::CTRL_EN_STAT]);
endmodule
